/* File: verilog/dcw_interpreter.sv */
// Drive command word interpreter and state report generator
`timescale 1ns/100ps
`default_nettype none
`include "dcw_map.svh"

module dcw_interpreter (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // Process data from the fieldbus master
    input wire logic [15:0] command_word,
    input wire logic command_valid,
    // Parameter-written command word
    input wire logic [15:0] command_param,
    input wire logic command_param_write,
    // Configuration
    input wire dcw_pkg::dcw_config_type config_in,
    // Pins
    input wire dcw_pkg::dcw_contacts_type contacts,
    // Drive core status
    input wire dcw_pkg::dcw_status_in_type core_status,
    // State report to the master
    output logic [15:0] inverter_state_report,
    // Readbacks
    output logic [2:0] active_data_set,
    output logic [7:0] op_source,
    output logic [4:0] digital_input_monitor,
    output logic [7:0] mode_of_operation,
    output logic [7:0] warning_cause,
    // Drive commands
    output logic run_clockwise,
    output logic run_anticlockwise,
    output logic drive_enable,
    output logic quick_stop,
    output logic halt,
    output logic [2:0] mode_specific,
    output logic fault_clear
);

    // -----------------------------------------------------------------
    // Declarations
    // -----------------------------------------------------------------
    dcw_pkg::dcw_state_type state; // State-machine mode state
    dcw_pkg::dcw_state_type next_state; // Its next value
    logic [15:0] cmd; // Latched effective command
    logic prev_fault_reset; // Bit 7 of the latched command one cycle earlier
    logic src_contacts; // Source 0
    logic src_remote; // Source 2
    logic src_sm; // Source 1
    logic sto_ok; // Both channels released
    logic start_cw; // Start clockwise after source mux
    logic start_ccw; // Start anticlockwise after source mux
    logic release_ok; // Enable-operation gate
    logic contact_enabled; // Contact-mode drive enable
    logic inverter_enabled; // Drive running, any source
    logic fault_reset_edge; // Rising bit 7
    logic [15:0] next_report; // Next state report

    // -----------------------------------------------------------------
    // Data set selection
    // -----------------------------------------------------------------

    // Data set picks which source value applies
    dcw_data_set_select u_ds (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .data_set_selection(config_in.data_set_selection),
        .data_set_contacts(contacts.data_set_contacts),
        .inverter_enabled(inverter_enabled),
        .active_data_set(active_data_set)
    );

    // -----------------------------------------------------------------
    // Operation source
    // -----------------------------------------------------------------

    // source follows the active data set
    always_comb begin
        unique case (active_data_set)
            3'h2: op_source = config_in.op_source_ds2;
            3'h3: op_source = config_in.op_source_ds3;
            3'h4: op_source = config_in.op_source_ds4;
            default: op_source = config_in.op_source_ds1;
        endcase
    end

    // only values 0 to 2 act; others leave the bus idle
    assign src_contacts = (op_source == `DCW_SRC_CONTACTS);
    assign src_sm = (op_source == `DCW_SRC_STATE_MACHINE);
    assign src_remote = (op_source == `DCW_SRC_REMOTE);

    // -----------------------------------------------------------------
    // Command capture
    // -----------------------------------------------------------------

    // first output word carries the command
    // parameter write counts like a bus word
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            cmd <= 16'h0000;
        end else if (command_valid) begin
            cmd <= command_word;
        end else if (command_param_write) begin
            cmd <= command_param;
        end
    end

    // Previous bit 7 for edge detection
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            prev_fault_reset <= 1'b0;
        end else begin
            prev_fault_reset <= cmd[`DCW_CMD_FAULT_RESET];
        end
    end

    // fault cleared by a rising bit 7
    assign fault_reset_edge = cmd[`DCW_CMD_FAULT_RESET] && !prev_fault_reset;

    // -----------------------------------------------------------------
    // Start inputs and release
    // -----------------------------------------------------------------
    assign sto_ok = contacts.safe_torque_off_channel_a && contacts.safe_torque_off_channel_b;

    // Start sources are pins in contact mode, virtual bits in remote mode
    always_comb begin
        start_cw = 1'b0;
        start_ccw = 1'b0;
        if (src_contacts || src_sm) begin
            start_cw = contacts.start_clockwise_input;
            start_ccw = contacts.start_anticlockwise_input;
        end else if (src_remote) begin
            start_cw = cmd[`DCW_CMD_VIRT_CW];
            start_ccw = cmd[`DCW_CMD_VIRT_CCW];
        end
    end

    // channels, plus a start input outside motion config
    assign release_ok = sto_ok && (config_in.motion_config || start_cw || start_ccw);

    // contact mode runs on release and start pins
    // remote mode also needs command bit 0
    always_comb begin
        contact_enabled = 1'b0;
        if (src_contacts) begin
            contact_enabled = sto_ok && (start_cw || start_ccw) && core_status.mains_present;
        end else if (src_remote) begin
            contact_enabled = sto_ok && cmd[`DCW_CMD_START] && (start_cw || start_ccw)
                && core_status.mains_present;
        end
    end

    // -----------------------------------------------------------------
    // State machine for source 1
    // -----------------------------------------------------------------

    // Next state from the command pattern
    always_comb begin
        next_state = state;
        if (core_status.fault_active) begin
            next_state = dcw_pkg::DCW_FAULT;
        end else if (!src_sm) begin
            next_state = dcw_pkg::DCW_SWITCH_ON_DISABLED;
        end else begin
            unique case (state)
                dcw_pkg::DCW_FAULT: begin
                    if (fault_reset_edge) next_state = dcw_pkg::DCW_SWITCH_ON_DISABLED;
                end
                dcw_pkg::DCW_SWITCH_ON_DISABLED: begin
                    if (cmd[2:0] == `DCW_SHUTDOWN_PATTERN) next_state = dcw_pkg::DCW_READY;
                end
                dcw_pkg::DCW_READY: begin
                    if (!cmd[`DCW_CMD_ENABLE_VOLTAGE] || !cmd[`DCW_CMD_QUICK_STOP_N])
                        next_state = dcw_pkg::DCW_SWITCH_ON_DISABLED;
                    else if (cmd[3:0] == `DCW_SWITCH_ON_PATTERN && core_status.mains_present)
                        next_state = dcw_pkg::DCW_SWITCHED_ON;
                end
                dcw_pkg::DCW_SWITCHED_ON: begin
                    if (!cmd[`DCW_CMD_ENABLE_VOLTAGE] || !cmd[`DCW_CMD_QUICK_STOP_N])
                        next_state = dcw_pkg::DCW_SWITCH_ON_DISABLED;
                    else if (!cmd[`DCW_CMD_START])
                        next_state = dcw_pkg::DCW_READY;
                    else if (cmd[3:0] == `DCW_ENABLE_PATTERN && release_ok)
                        next_state = dcw_pkg::DCW_OP_ENABLED;
                end
                dcw_pkg::DCW_OP_ENABLED: begin
                    if (!cmd[`DCW_CMD_ENABLE_VOLTAGE])
                        next_state = dcw_pkg::DCW_SWITCH_ON_DISABLED;
                    else if (!cmd[`DCW_CMD_QUICK_STOP_N])
                        next_state = dcw_pkg::DCW_QUICK_STOP;
                    else if (!cmd[`DCW_CMD_START])
                        next_state = dcw_pkg::DCW_READY;
                    // Release lost drops back to switched on
                    else if (!cmd[`DCW_CMD_ENABLE_OP] || !release_ok)
                        next_state = dcw_pkg::DCW_SWITCHED_ON;
                end
                dcw_pkg::DCW_QUICK_STOP: begin
                    if (!cmd[`DCW_CMD_ENABLE_VOLTAGE])
                        next_state = dcw_pkg::DCW_SWITCH_ON_DISABLED;
                end
            endcase
        end
    end

    // State register
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            state <= dcw_pkg::DCW_SWITCH_ON_DISABLED;
        end else begin
            state <= next_state;
        end
    end

    // state-machine mode drives from the command word
    assign inverter_enabled = src_sm ? (state == dcw_pkg::DCW_OP_ENABLED) : contact_enabled;

    // -----------------------------------------------------------------
    // Drive command outputs
    // -----------------------------------------------------------------

    // Registered drive commands; direction from start inputs
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            drive_enable <= 1'b0;
            run_clockwise <= 1'b0;
            run_anticlockwise <= 1'b0;
            quick_stop <= 1'b0;
            fault_clear <= 1'b0;
        end else begin
            drive_enable <= inverter_enabled && !core_status.fault_active;
            run_clockwise <= inverter_enabled && start_cw;
            run_anticlockwise <= inverter_enabled && start_ccw && !start_cw;
            quick_stop <= src_sm && (state == dcw_pkg::DCW_QUICK_STOP);
            fault_clear <= fault_reset_edge && (src_sm || src_remote || src_contacts);
        end
    end

    // bits 4..6 and halt only in motion config and source 1
    // positioning only with state machine source
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            halt <= 1'b0;
            mode_specific <= 3'h0;
        end else if (config_in.motion_config && src_sm) begin
            halt <= cmd[`DCW_CMD_HALT];
            mode_specific <= cmd[6:4];
        end else begin
            halt <= 1'b0;
            mode_specific <= 3'h0;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            mode_of_operation <= `DCW_MODE_VELOCITY;
        end else if (!(src_sm && config_in.motion_config)) begin
            mode_of_operation <= `DCW_MODE_VELOCITY;
        end
    end

    // -----------------------------------------------------------------
    // Monitors
    // -----------------------------------------------------------------

    // release shown only with channels and bit 0
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            digital_input_monitor <= 5'h00;
        end else begin
            digital_input_monitor[0] <= sto_ok && cmd[`DCW_CMD_START];
            digital_input_monitor[1] <= start_cw;
            digital_input_monitor[2] <= start_ccw;
            digital_input_monitor[3] <= src_remote ? cmd[`DCW_CMD_VIRT_IN3]
                                                   : contacts.extension_digital_input_three;
            digital_input_monitor[4] <= sto_ok;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            warning_cause <= 8'h00;
        end else begin
            warning_cause <= {2'h0, core_status.delayed_warning, core_status.limit_active,
                              core_status.fault_active, 2'h0, core_status.internal_warning};
        end
    end

    // -----------------------------------------------------------------
    // State report
    // -----------------------------------------------------------------

    // Builds the report word; unlisted bits stay zero
    always_comb begin
        next_report = 16'h0000;
        if (src_sm) begin
            unique case (state)
                dcw_pkg::DCW_SWITCH_ON_DISABLED: next_report[5:0] = `DCW_RPT_SM_DISABLED;
                dcw_pkg::DCW_READY: next_report[5:0] = `DCW_RPT_SM_READY;
                dcw_pkg::DCW_SWITCHED_ON: next_report[5:0] = `DCW_RPT_SM_SWITCHED;
                dcw_pkg::DCW_OP_ENABLED: next_report[5:0] = `DCW_RPT_SM_ENABLED;
                dcw_pkg::DCW_QUICK_STOP: next_report[5:0] = `DCW_RPT_SM_QSTOP;
                dcw_pkg::DCW_FAULT: next_report[5:0] = `DCW_RPT_SM_FAULT;
            endcase
            next_report[6] = (state == dcw_pkg::DCW_SWITCH_ON_DISABLED);
        end else begin
            next_report[5:0] = contact_enabled ? `DCW_RPT_OP_ENABLED : `DCW_RPT_SWITCHED_ON;
        end
        if (core_status.fault_active) next_report[`DCW_RPT_FAULT] = 1'b1;
        next_report[`DCW_RPT_MAINS] = core_status.mains_present;
        next_report[`DCW_RPT_WARNING] = core_status.internal_warning;
        next_report[`DCW_RPT_REMOTE] = src_sm && sto_ok;
        next_report[`DCW_RPT_TARGET] = core_status.target_reached || core_status.power_fail_zero;
        next_report[`DCW_RPT_LIMIT] = core_status.limit_active;
        // mode bits only in motion config
        if (config_in.motion_config && src_sm) begin
            next_report[`DCW_RPT_MODE_HI:`DCW_RPT_MODE_LO] = core_status.mode_bits;
        end
        next_report[`DCW_RPT_WARNING2] = core_status.delayed_warning;
    end

    // report returned in first input word
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            inverter_state_report <= 16'h0000;
        end else begin
            inverter_state_report <= next_report;
        end
    end

endmodule : dcw_interpreter
`default_nettype wire

/* File: verilog/dcw_map.svh */
// Register fields, parameter codes and constants of the drive command interpreter
// What this block does
// - Command in first out word, report in first in word
// - Operation source from source setting, 0 to 2
// - Source 0: start, stop, direction from pins
// - Source 2: start, stop, direction from command bits
// - Source 1: state machine, positioning, modes only here
// - Source held per data set, remote bit follows
// - Selection 0 contacts choose, 1..4 force set
// - Selection 5 contacts choose only while disabled
// - Active data set reads 1 to 4
// - Input monitor shows release only with channels and bit0
// - Remote contacts start needs both channels and bit0
// - Contact modes support only velocity mode
// - Report bit 4 shows mains presence
// - Report bit 7 flags internal warning
// - Report bit 10 target reached or zero-frequency regulation
// - Report bit 11 internal limit active
// - Report bit 15 imminent fault warning
// - Enable operation needs channels, plus start outside motion
// - State-machine command acts only with source 1
// - Bits 4,5,6,8 only in motion configuration
// - Report bits 12, 13 only in motion configuration
// - Rising bit 7 clears fault, enable pattern 1111
`ifndef DCW_MAP_SVH
`define DCW_MAP_SVH

// -----------------------------------------------------------------
// Operation source codes
// -----------------------------------------------------------------
`define DCW_SRC_CONTACTS 8'h00
`define DCW_SRC_STATE_MACHINE 8'h01
`define DCW_SRC_REMOTE 8'h02

// -----------------------------------------------------------------
// Data set selection codes
// -----------------------------------------------------------------
`define DCW_DSS_CONTACTS 3'h0
`define DCW_DSS_MAX_FORCED 3'h4
`define DCW_DSS_WHEN_DISABLED 3'h5

// -----------------------------------------------------------------
// Command word bit positions
// -----------------------------------------------------------------
`define DCW_CMD_START 0
`define DCW_CMD_ENABLE_VOLTAGE 1
`define DCW_CMD_QUICK_STOP_N 2
`define DCW_CMD_ENABLE_OP 3
`define DCW_CMD_FAULT_RESET 7
`define DCW_CMD_HALT 8
`define DCW_CMD_VIRT_CW 9
`define DCW_CMD_VIRT_CCW 10
`define DCW_CMD_VIRT_IN3 11
`define DCW_CMD_UNUSED 14

// -----------------------------------------------------------------
// State report bit positions and patterns
// -----------------------------------------------------------------
`define DCW_RPT_FAULT 3
`define DCW_RPT_MAINS 4
`define DCW_RPT_WARNING 7
`define DCW_RPT_REMOTE 9
`define DCW_RPT_TARGET 10
`define DCW_RPT_LIMIT 11
`define DCW_RPT_MODE_LO 12
`define DCW_RPT_MODE_HI 13
`define DCW_RPT_WARNING2 15
`define DCW_RPT_SWITCHED_ON 6'h23
`define DCW_RPT_OP_ENABLED 6'h37
`define DCW_RPT_SM_DISABLED 6'h00
`define DCW_RPT_SM_READY 6'h21
`define DCW_RPT_SM_SWITCHED 6'h23
`define DCW_RPT_SM_ENABLED 6'h27
`define DCW_RPT_SM_QSTOP 6'h07
`define DCW_RPT_SM_FAULT 6'h08
`define DCW_ENABLE_PATTERN 4'hF
`define DCW_SWITCH_ON_PATTERN 4'h7
`define DCW_SHUTDOWN_PATTERN 3'h6

// -----------------------------------------------------------------
// Misc values
// -----------------------------------------------------------------
`define DCW_MODE_VELOCITY 8'h02
`define DCW_RESET_DATA_SET 3'h1

`endif

/* File: verilog/dcw_pkg.sv */
// Types shared by the drive command interpreter files
package dcw_pkg;

    // Drive state of the command path
    typedef enum logic [2:0] {
        DCW_SWITCH_ON_DISABLED,
        DCW_READY,
        DCW_SWITCHED_ON,
        DCW_OP_ENABLED,
        DCW_QUICK_STOP,
        DCW_FAULT
    } dcw_state_type;

    // Status inputs from the drive core
    typedef struct packed {
        logic mains_present;
        logic internal_warning;
        logic target_reached;
        logic power_fail_zero;
        logic limit_active;
        logic delayed_warning;
        logic fault_active;
        logic [1:0] mode_bits;
    } dcw_status_in_type;

    // Physical contact inputs
    typedef struct packed {
        logic safe_torque_off_channel_a;
        logic safe_torque_off_channel_b;
        logic start_clockwise_input;
        logic start_anticlockwise_input;
        logic extension_digital_input_three;
        logic [3:0] data_set_contacts;
    } dcw_contacts_type;

    // Per data set configuration
    typedef struct packed {
        logic [7:0] op_source_ds4;
        logic [7:0] op_source_ds3;
        logic [7:0] op_source_ds2;
        logic [7:0] op_source_ds1;
        logic [2:0] data_set_selection;
        logic motion_config;
    } dcw_config_type;

endpackage : dcw_pkg

/* File: verilog/dcw_data_set_select.sv */
// Active data set selection logic
`timescale 1ns/100ps
`default_nettype none
`include "dcw_map.svh"

module dcw_data_set_select (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // Selection controls
    input wire logic [2:0] data_set_selection,
    input wire logic [3:0] data_set_contacts,
    input wire logic inverter_enabled,
    // Result, value 1 to 4
    output logic [2:0] active_data_set
);

    // -----------------------------------------------------------------
    // Contact decode
    // -----------------------------------------------------------------

    // Lowest asserted contact wins; none keeps the first set
    function automatic logic [2:0] dcw_contact_decode(input logic [3:0] c);
        logic [2:0] r;
        r = `DCW_RESET_DATA_SET;
        if (c[3]) r = 3'h4;
        if (c[2]) r = 3'h3;
        if (c[1]) r = 3'h2;
        if (c[0]) r = 3'h1;
        return r;
    endfunction : dcw_contact_decode

    // -----------------------------------------------------------------
    // Selection register
    // -----------------------------------------------------------------

    // Data set held per the selection mode
    // reads one to four
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            active_data_set <= `DCW_RESET_DATA_SET;
        end else if (data_set_selection == `DCW_DSS_CONTACTS) begin
            active_data_set <= dcw_contact_decode(data_set_contacts);
        end else if (data_set_selection <= `DCW_DSS_MAX_FORCED) begin
            active_data_set <= data_set_selection;
        // contacts only while disabled; else hold
        end else if (data_set_selection == `DCW_DSS_WHEN_DISABLED && !inverter_enabled) begin
            active_data_set <= dcw_contact_decode(data_set_contacts);
        end
    end

endmodule : dcw_data_set_select
`default_nettype wire

/* File: bench/dcw_master_model.sv */
// Fieldbus master model that hands command words to the interpreter
`timescale 1ns/100ps
`default_nettype none
module dcw_master_model (
    // Clock
    input wire logic core_clk,
    // First output process word
    output logic [15:0] command_word,
    output logic command_valid
);
    // Idle master: word zero, no strobe
    initial begin
        command_word = 16'h0000;
        command_valid = 1'b0;
    end
    task automatic send(input logic [15:0] w);
        @(negedge core_clk);
        command_word = w;
        command_valid = 1'b1;
        @(negedge core_clk);
        command_valid = 1'b0;
    endtask : send
endmodule : dcw_master_model
`default_nettype wire

/* File: bench/dcw_interpreter_assertions.sv */
// Port checks for the drive command interpreter
`timescale 1ns/100ps
`default_nettype none
module dcw_interpreter_assertions (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst_n,
    // Inputs seen
    input wire dcw_pkg::dcw_config_type config_in,
    input wire dcw_pkg::dcw_contacts_type contacts,
    input wire dcw_pkg::dcw_status_in_type core_status,
    // Outputs seen
    input wire logic [15:0] inverter_state_report,
    input wire logic [2:0] active_data_set,
    input wire logic [4:0] digital_input_monitor,
    input wire logic [7:0] mode_of_operation,
    input wire logic fault_clear
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    // Report bits follow the core one edge late; skip the edge after reset
    mains_bit_a:
        assert property ($past(rst_n) |-> inverter_state_report[4] == $past(core_status.mains_present))
        else $error("mains bit wrong");
    warning_bit_a:
        assert property ($past(rst_n) |-> inverter_state_report[7] == $past(core_status.internal_warning))
        else $error("warning bit wrong");
    target_bit_a:
        assert property ($past(rst_n) |-> inverter_state_report[10] ==
            $past(core_status.target_reached | core_status.power_fail_zero))
        else $error("target bit wrong");
    limit_bit_a:
        assert property ($past(rst_n) |-> inverter_state_report[11] == $past(core_status.limit_active))
        else $error("limit bit wrong");
    trip_warning_a:
        assert property ($past(rst_n) |-> inverter_state_report[15] == $past(core_status.delayed_warning))
        else $error("warning two bit wrong");
    mode_bits_zero_a:
        assert property ($past(rst_n) && !$past(config_in.motion_config) |-> inverter_state_report[14:12] == 3'h0)
        else $error("mode bits not zero");
    sto_monitor_a:
        assert property ($past(rst_n) |-> digital_input_monitor[4] ==
            $past(contacts.safe_torque_off_channel_a & contacts.safe_torque_off_channel_b))
        else $error("release monitor wrong");
    release_needs_sto_a:
        assert property (digital_input_monitor[0] |-> digital_input_monitor[4])
        else $error("release shown without channels");
    clear_pulse_a:
        assert property (fault_clear |=> !fault_clear)
        else $error("fault clear too long");
    data_set_range_a:
        assert property (active_data_set inside {[3'h1:3'h4]})
        else $error("data set out of range");
    velocity_only_a:
        assert property ($past(rst_n) && !$past(config_in.motion_config) |-> mode_of_operation == 8'h02)
        else $error("mode not velocity");
    // Main scenarios reached
    cover property (fault_clear);
    cover property (digital_input_monitor[0]);
    cover property (active_data_set == 3'h3);
endmodule : dcw_interpreter_assertions
bind dcw_interpreter dcw_interpreter_assertions i_dcw_interpreter_assertions (.core_clk, .rst_n, .config_in,
    .contacts, .core_status, .inverter_state_report, .active_data_set, .digital_input_monitor,
    .mode_of_operation, .fault_clear);
`default_nettype wire

/* File: bench/testbench.sv */
// Self-checking bench for the drive command interpreter
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, e, a) begin cmp_count++; if ((a) !== (e)) begin n_mismatch++; \
    $display("Error %s expected %h seen %h", nm, e, a); end end
module testbench;
    logic core_clk, rst_n, cv, rcw, fclr, den, cpw;
    dcw_pkg::dcw_config_type cfg;
    dcw_pkg::dcw_contacts_type pins;
    dcw_pkg::dcw_status_in_type st;
    logic [15:0] cw, rpt, cp;
    logic [2:0] ads;
    logic [7:0] src, mode, wc;
    logic [4:0] mon;
    int n_mismatch = 0;
    int cmp_count = 0;
    int rb[6] = '{4, 7, 10, 10, 11, 15};
    logic [15:0] smw[3] = '{16'h0006, 16'h0007, 16'h000F};
    logic [6:0] sme[3] = '{7'h21, 7'h23, 7'h27};
    // 200 MHz clock
    initial begin
        core_clk = 1'b0;
        forever #2.5 core_clk = ~core_clk;
    end
    dcw_master_model i_dcw_master_model (.core_clk(core_clk), .command_word(cw), .command_valid(cv));
    dcw_interpreter i_dcw_interpreter (.core_clk(core_clk), .rst_n(rst_n), .command_word(cw),
        .command_valid(cv), .command_param(cp), .command_param_write(cpw), .config_in(cfg),
        .contacts(pins), .core_status(st), .inverter_state_report(rpt), .active_data_set(ads),
        .op_source(src), .digital_input_monitor(mon), .mode_of_operation(mode), .warning_cause(wc),
        .run_clockwise(rcw), .run_anticlockwise(), .drive_enable(den), .quick_stop(), .halt(),
        .mode_specific(), .fault_clear(fclr));
    task automatic wt(input int n);
        repeat (n) @(negedge core_clk);
    endtask : wt
    // Send a word, then let the two-edge answer settle
    task automatic cmd(input logic [15:0] w);
        i_dcw_master_model.send(w);
        wt(4);
    endtask : cmd
    task automatic test_done();
        $display("Comparisons %0d mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : test_done
    // Main sequence
    initial begin
        rst_n = 1'b0;
        cfg = '0;
        pins = '0;
        cp = 16'h0000;
        cpw = 1'b0;
        st = '0;
        cfg.op_source_ds3 = 8'h02;
        wt(6);
        rst_n = 1'b1;
        wt(2);
        `CHK("data set", 3'h1, ads)
        `CHK("mode", 8'h02, mode)
        for (int i = 0; i < 6; i++) begin
            st = 9'(9'h100 >> i);
            wt(3);
            `CHK("status bit", 1'b1, rpt[rb[i]])
            `CHK("mains bit", i == 0, rpt[4])
            if (i == 1) `CHK("warning cause", 8'h01, wc)
        end
        st = '0;
        st.mains_present = 1'b1;
        pins.safe_torque_off_channel_a = 1'b1;
        pins.safe_torque_off_channel_b = 1'b1;
        pins.start_clockwise_input = 1'b1;
        cmd(16'h0000);
        `CHK("contact run", 6'h27, rpt[5:0] & 6'h2F)
        `CHK("run cw", 1'b1, rcw)
        pins.start_clockwise_input = 1'b0;
        cmd(16'h000F);
        `CHK("contact stop", 6'h23, rpt[5:0] & 6'h2F)
        `CHK("remote bit", 1'b0, rpt[9])
        cfg.data_set_selection = 3'h3;
        wt(3);
        `CHK("forced set", 3'h3, ads)
        `CHK("set source", 8'h02, src)
        cmd(16'h0200);
        `CHK("no bit0 run", 1'b0, rcw)
        `CHK("no bit0 mon", 1'b0, mon[0])
        cmd(16'h0201);
        `CHK("virtual run", 1'b1, rcw)
        `CHK("bit0 mon", 1'b1, mon[0])
        pins.data_set_contacts = 4'h1;
        cfg.data_set_selection = 3'h5;
        wt(3);
        `CHK("held set", 3'h3, ads)
        cmd(16'h0200);
        wt(3);
        `CHK("contact set", 3'h1, ads)
        cfg.op_source_ds1 = 8'h01;
        cfg.data_set_selection = 3'h1;
        pins.start_clockwise_input = 1'b1;
        for (int i = 0; i < 3; i++) begin
            cmd(smw[i]);
            `CHK("machine state", sme[i], rpt[6:0] & 7'h6F)
        end
        `CHK("enable", 1'b1, den)
        `CHK("remote on", 1'b1, rpt[9])
        pins.safe_torque_off_channel_b = 1'b0;
        wt(4);
        `CHK("sto drop", 1'b0, rpt[2])
        // Parameter-written shutdown takes the same path as a bus word
        cp = 16'h0006;
        cpw = 1'b1;
        wt(1);
        cpw = 1'b0;
        wt(4);
        `CHK("param word", 7'h21, rpt[6:0] & 7'h6F)
        st.fault_active = 1'b1;
        cmd(16'h0000);
        i_dcw_master_model.send(16'h0080);
        for (int k = 0; k < 6 && fclr !== 1'b1; k++)
            @(negedge core_clk);
        `CHK("fault clear", 1'b1, fclr)
        test_done();
    end
endmodule : testbench
`default_nettype wire
